/* File: rtl/contact_input_debounce.sv */
// Purpose: contact input scan, debounce, stamping, events, operands
// Assumes: voltage codes and period from logic on pclk
// Notes: APB slave with one wait state on every access
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`include "debounce_regs.svh"
module contact_input_debounce #(
    parameter int SCAN_US = `SCAN_PERIOD_US
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire debounce_pkg::volt_bus_t   volt_in,
    input  wire logic [`PASS_W-1:0]        freq_period,
    output logic [`N_IN-1:0]               input_closed_operand,
    output logic                           pass_start,
    output debounce_pkg::event_s           event_out,
    output logic                           irq
);
    import debounce_pkg::*;

    localparam logic [6:0] US_LAST   = 7'(`US_CYCLES - 1);
    localparam logic [9:0] SCAN_LAST = 10'(SCAN_US - 1);

    top_s                   st;
    top_s                   next_st;
    logic [`N_IN-1:0]       sample_bus;
    logic [`N_IN-1:0]       closed_bus;
    logic [`N_IN-1:0]       change_bus;
    stamp_t [`N_IN-1:0]     stamp_bus;
    logic                   done;
    logic                   wr;
    logic                   us_step;
    logic [`PASS_W-1:0]     pass_len;

    assign done     = psel && penable && st.pready;
    assign wr       = done && pwrite;
    assign us_step  = st.us_pre == US_LAST;
    // eighth of the tracked power cycle
    assign pass_len = freq_period >> `PASSES_LOG2;

    for (genvar g = 0; g < `N_IN; g++) begin : g_in
        assign sample_bus[g] = volt_in[g] >= st.thr[g / `GRP_SIZE];

        debounce_channel u_ch (
            .pclk      (pclk),
            .presetn   (presetn),
            .tick      (st.tick),
            .sample    (sample_bus[g]),
            .interval  (st.deb),
            .now_us    (st.us_cnt),
            .closed    (closed_bus[g]),
            .change    (change_bus[g]),
            .stamp_out (stamp_bus[g])
        );
    end

    always_comb begin
        logic [31:0]      rdata;
        logic             hit;
        logic             found;
        logic [`N_IN-1:0] w1c;
        rdata = 32'h0;
        hit   = 1'b1;
        found = 1'b0;
        w1c   = '0;
        next_st = st;

        unique case (paddr)
            `ADDR_CTRL:    rdata = {31'h0, st.scan_en};
            `ADDR_DEB:     rdata = {24'h0, st.deb};
            `ADDR_THR:     rdata = st.thr;
            `ADDR_EV_EN:   rdata = {16'h0, st.ev_en};
            `ADDR_STATUS:  rdata = {16'h0, st.status};
            `ADDR_MASK:    rdata = {16'h0, st.mask};
            `ADDR_STATE:   rdata = {16'h0, closed_bus};
            `ADDR_OPERAND: rdata = {16'h0, st.operand};
            `ADDR_TIME:    rdata = st.us_cnt;
            default:       hit   = 1'b0;
        endcase

        // one wait state keeps the answer in a flop
        if (psel && penable && !st.pready) begin
            next_st.pready  = 1'b1;
            next_st.prdata  = hit ? rdata : 32'h0;
            next_st.pslverr = !hit;
        end else begin
            next_st.pready  = 1'b0;
            next_st.pslverr = 1'b0;
        end

        if (wr && hit) begin
            unique case (paddr)
                `ADDR_CTRL:   next_st.scan_en = pwdata[`CTRL_SCAN_BIT];
                `ADDR_DEB:    next_st.deb     = pwdata[`DEB_W-1:0];
                `ADDR_THR:    next_st.thr     = pwdata;
                `ADDR_EV_EN:  next_st.ev_en   = pwdata[`N_IN-1:0];
                `ADDR_STATUS: w1c             = pwdata[`N_IN-1:0];
                `ADDR_MASK:   next_st.mask    = pwdata[`N_IN-1:0];
                default:      w1c             = '0;
            endcase
        end

        next_st.us_pre = us_step ? 7'h00 : st.us_pre + 7'h01;
        if (us_step) begin
            next_st.us_cnt = st.us_cnt + 32'h1;
            if (st.scan_pre == SCAN_LAST) begin
                next_st.scan_pre = 10'h000;
            end else begin
                next_st.scan_pre = st.scan_pre + 10'h001;
            end
        end
        next_st.tick = us_step && st.scan_pre == SCAN_LAST && st.scan_en;

        next_st.pass_start = 1'b0;
        if (pass_len == '0) begin
            next_st.pass_cnt = '0;
        end else if (st.pass_cnt + 24'h1 >= pass_len) begin
            next_st.pass_cnt   = '0;
            next_st.pass_start = 1'b1;
            next_st.operand    = closed_bus;
        end else begin
            next_st.pass_cnt = st.pass_cnt + 24'h1;
        end

        // one event per cycle, lowest input first
        next_st.ev.valid = 1'b0;
        for (int i = 0; i < `N_IN; i++) begin
            if (st.pend[i] && !found) begin
                found             = 1'b1;
                next_st.ev.valid  = 1'b1;
                next_st.ev.chan   = 4'(i);
                next_st.ev.closed = closed_bus[i];
                next_st.ev.stamp  = stamp_bus[i];
                next_st.pend[i]   = 1'b0;
            end
        end
        // a fresh change beats the clear of the same cycle
        next_st.pend   = next_st.pend | (change_bus & st.ev_en);
        next_st.status = (st.status & ~w1c) | change_bus;
        next_st.irq    = |(next_st.status & next_st.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st         <= '0;
            st.scan_en <= `CTRL_RST;
            st.deb     <= `DEB_RST;
            st.thr     <= `THR_RST;
            st.mask    <= `MASK16_RST;
        end else begin
            st <= next_st;
        end
    end

    assign prdata               = st.prdata;
    assign pready               = st.pready;
    assign pslverr              = st.pslverr;
    assign input_closed_operand = st.operand;
    assign pass_start           = st.pass_start;
    assign event_out            = st.ev;
    assign irq                  = st.irq;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_tick_cause;
        st.tick |-> $past(st.scan_pre) == SCAN_LAST && $past(st.us_pre) == US_LAST;
    endproperty
    a_tick_cause: assert property (p_tick_cause) else $error("scan tick off period");

    property p_us_step;
        $changed(st.us_cnt) |-> $past(st.us_pre) == US_LAST
            && st.us_cnt == $past(st.us_cnt) + 32'h1;
    endproperty
    a_us_step: assert property (p_us_step) else $error("time base not 1 us");

    property p_pass_gap;
        pass_start |-> $past(pass_len) != '0
            && $past(st.pass_cnt) + 24'h1 >= $past(pass_len);
    endproperty
    a_pass_gap: assert property (p_pass_gap) else $error("pass off tracked period");

    property p_operand_copy;
        pass_start |-> input_closed_operand == $past(closed_bus);
    endproperty
    a_operand_copy: assert property (p_operand_copy) else $error("operand not copied");

    property p_operand_hold;
        !pass_start |-> $stable(input_closed_operand);
    endproperty
    a_operand_hold: assert property (p_operand_hold) else $error("operand moved mid pass");

    property p_event_stamp;
        st.pend[0] |=> event_out.valid && event_out.chan == 4'h0
            && event_out.stamp == $past(stamp_bus[0]);
    endproperty
    a_event_stamp: assert property (p_event_stamp) else $error("event stamp wrong");

    property p_event_raised;
        |(change_bus & st.ev_en) |=> |st.pend || event_out.valid;
    endproperty
    a_event_raised: assert property (p_event_raised) else $error("event lost");

    property p_irq_level;
        irq == |(st.status & st.mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

    // bus answer shape
    property p_pready_pulse;
        pready |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready held too long");

    property p_slverr_ready;
        pslverr |-> pready;
    endproperty
    a_slverr_ready: assert property (p_slverr_ready) else $error("error without ready");

    property p_apb_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("access not answered");

    property p_wr_refused;
        wr && paddr > `ADDR_TIME
            |=> $stable(st.mask) && $stable(st.ev_en) && $stable(st.deb);
    endproperty
    a_wr_refused: assert property (p_wr_refused) else $error("unmapped write landed");

    // scan tick, prescaler and pass shape
    property p_tick_gated;
        !st.scan_en |=> !st.tick;
    endproperty
    a_tick_gated: assert property (p_tick_gated) else $error("tick while scan off");

    property p_tick_pulse;
        st.tick |=> !st.tick;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("tick too wide");

    property p_us_wrap;
        us_step |=> st.us_pre == 7'h00;
    endproperty
    a_us_wrap: assert property (p_us_wrap) else $error("us prescaler not wrapped");

    property p_pass_none;
        pass_len == '0 |=> !pass_start;
    endproperty
    a_pass_none: assert property (p_pass_none) else $error("pass without period");

    property p_pass_reload;
        pass_start |-> st.pass_cnt == '0;
    endproperty
    a_pass_reload: assert property (p_pass_reload) else $error("pass count not reloaded");

    // event and status
    property p_status_set;
        |change_bus
            |=> (st.status & $past(change_bus)) == $past(change_bus);
    endproperty
    a_status_set: assert property (p_status_set) else $error("status not set");

    property p_stray_event;
        st.pend == '0 |=> !event_out.valid;
    endproperty
    a_stray_event: assert property (p_stray_event) else $error("event not pending");

    property p_w1c_clear;
        wr && paddr == `ADDR_STATUS && change_bus == '0
            |=> (st.status & $past(pwdata[`N_IN-1:0])) == '0;
    endproperty
    a_w1c_clear: assert property (p_w1c_clear) else $error("status not cleared");

    c_event: cover property (event_out.valid && event_out.closed);
    c_pass_new: cover property (pass_start && input_closed_operand != $past(st.operand));
    c_irq: cover property (irq);
endmodule : contact_input_debounce

/* File: rtl/debounce_channel.sv */
// Purpose: debounce and time stamp of one contact input
// Assumes: tick is one cycle wide, sample valid with it
// Notes: interval counts scan steps after the first sample
`timescale 1ns/1ns
`include "debounce_regs.svh"
module debounce_channel (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 tick,
    input  wire logic                 sample,
    input  wire logic [`DEB_W-1:0]    interval,
    input  wire debounce_pkg::stamp_t now_us,
    output logic                      closed,
    output logic                      change,
    output debounce_pkg::stamp_t      stamp_out
);
    import debounce_pkg::*;

    chan_s             st;
    chan_s             next_st;
    logic [`DEB_W-1:0] run_len;
    stamp_t            first_stamp;

    assign run_len     = st.run ? st.cnt + 8'h01 : 8'h00;
    assign first_stamp = st.run ? st.stamp : now_us;

    always_comb begin
        next_st = st;
        next_st.change = 1'b0;
        if (tick) begin
            if (sample == st.closed) begin
                next_st.run = 1'b0;
            end else if (run_len >= interval) begin
                next_st.closed    = sample;
                next_st.run       = 1'b0;
                next_st.change    = 1'b1;
                next_st.stamp_out = first_stamp;
            end else begin
                next_st.run   = 1'b1;
                next_st.cnt   = run_len;
                next_st.stamp = first_stamp;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign closed    = st.closed;
    assign change    = st.change;
    assign stamp_out = st.stamp_out;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_restart;
        tick && sample == st.closed |=> !st.run && !st.change;
    endproperty
    a_restart: assert property (p_restart) else $error("run not restarted");

    property p_validate;
        tick && sample != st.closed && run_len >= interval
            |=> st.change && st.closed == $past(sample);
    endproperty
    a_validate: assert property (p_validate) else $error("late validation");

    property p_hold_short;
        tick && sample != st.closed && run_len < interval
            |=> $stable(st.closed) && st.run;
    endproperty
    a_hold_short: assert property (p_hold_short) else $error("early validation");

    property p_first_stamp;
        tick && !st.run && sample != st.closed && interval != 8'h00
            |=> st.stamp == $past(now_us);
    endproperty
    a_first_stamp: assert property (p_first_stamp) else $error("bad first stamp");

    c_validate: cover property (st.change && st.closed);
    c_release: cover property (st.change && !st.closed);
endmodule : debounce_channel

/* File: rtl/debounce_pkg.sv */
// Purpose: shared types of the contact input debounce block
// Assumes: debounce_regs.svh gives the sizes
// Notes: one struct holds all state of each module
`include "debounce_regs.svh"
package debounce_pkg;
    typedef logic [`STAMP_W-1:0] stamp_t;
    typedef logic [`VOLT_W-1:0]  volt_t;
    typedef volt_t [`N_IN-1:0]   volt_bus_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] chan;
        logic       closed;
        stamp_t     stamp;
    } event_s;

    typedef struct packed {
        logic              run;
        logic              closed;
        logic              change;
        logic [`DEB_W-1:0] cnt;
        stamp_t            stamp;
        stamp_t            stamp_out;
    } chan_s;

    typedef struct packed {
        logic                              pready;
        logic                              pslverr;
        logic [31:0]                       prdata;
        logic                              scan_en;
        logic [`DEB_W-1:0]                 deb;
        logic [`N_GRP-1:0][`VOLT_W-1:0]    thr;
        logic [`N_IN-1:0]                  ev_en;
        logic [`N_IN-1:0]                  status;
        logic [`N_IN-1:0]                  mask;
        logic [`N_IN-1:0]                  pend;
        logic [`N_IN-1:0]                  operand;
        logic                              irq;
        event_s                            ev;
        logic [6:0]                        us_pre;
        stamp_t                            us_cnt;
        logic [9:0]                        scan_pre;
        logic                              tick;
        logic [`PASS_W-1:0]                pass_cnt;
        logic                              pass_start;
    } top_s;
endpackage : debounce_pkg

/* File: rtl/debounce_regs.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: included by its bare name, pclk at 100 MHz
// Notes: definitions only
`ifndef DEBOUNCE_REGS_SVH
`define DEBOUNCE_REGS_SVH

`define N_IN           16
`define GRP_SIZE       4
`define N_GRP          4
`define VOLT_W         8
`define DEB_W          8
`define STAMP_W        32
`define PASS_W         24
`define PASSES_LOG2    3

`define CLK_MHZ        100
`define STAMP_RES_US   1
`define US_CYCLES      (`CLK_MHZ * `STAMP_RES_US)
`define SCAN_PERIOD_US 500

`define ADDR_CTRL      12'h000
`define ADDR_DEB       12'h004
`define ADDR_THR       12'h008
`define ADDR_EV_EN     12'h00c
`define ADDR_STATUS    12'h010
`define ADDR_MASK      12'h014
`define ADDR_STATE     12'h018
`define ADDR_OPERAND   12'h01c
`define ADDR_TIME      12'h020

`define CTRL_SCAN_BIT  0
`define CTRL_RST       1'h1
`define DEB_RST        8'h05
`define THR_RST        32'h10101010
`define MASK16_RST     16'h0000

`endif

/* File: testbench/contact_field.sv */
// Purpose: field contacts as seen through the voltage sensing front end
// Assumes: one wetting level for every closed contact
// Notes: an open contact reads zero volts, no leakage modelled
`timescale 1ns/1ns
module contact_field (
    input  wire logic [15:0]             closed,
    input  wire debounce_pkg::volt_t     wet_lvl,
    output debounce_pkg::volt_bus_t      volt_in
);
    import debounce_pkg::*;
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            volt_in[i] = closed[i] ? wet_lvl : 8'h00;
        end
    end
endmodule : contact_field

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench of the contact input debounce block
// Assumes: SCAN_US = 2, so one scan is 200 cycles and 1 us is 100 cycles
// Notes: input changes land mid-scan so the sampling phase never matters
`timescale 1ns/1ns
`include "debounce_regs.svh"
module tb_top;
    import debounce_pkg::*;
    logic               pclk        = 1'b0;
    logic               presetn     = 1'b0;
    logic               psel        = 1'b0;
    logic               penable     = 1'b0;
    logic               pwrite      = 1'b0;
    logic [11:0]        paddr       = 12'h000;
    logic [31:0]        pwdata      = 32'h0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    volt_bus_t          volt_in;
    logic [`PASS_W-1:0] freq_period = 24'h000320;
    logic [`N_IN-1:0]   operand;
    logic [`N_IN-1:0]   op_prev     = 16'h0;
    logic               pass_start;
    event_s             event_out;
    event_s             ev;
    event_s             evq[$];
    logic               irq;
    logic [15:0]        closed      = 16'h0;
    logic [31:0]        d;
    logic               e;
    stamp_t             t0;
    int                 cyc         = 0;
    int                 gap         = 0;
    logic               gap_seen    = 1'b0;
    int                 error_cnt   = 0;
    int                 n_checks    = 0;

    always #5 pclk = ~pclk;

    contact_input_debounce #(.SCAN_US(2)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .volt_in(volt_in),
        .freq_period(freq_period), .input_closed_operand(operand),
        .pass_start(pass_start), .event_out(event_out), .irq(irq)
    );

    contact_field field_u (.closed(closed), .wet_lvl(8'h20), .volt_in(volt_in));

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task conclude;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    // bus master: request held until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
             output logic [31:0] rd, output logic err);
        int k;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            error_cnt++;
            conclude();
        end
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, d, e);
    endtask : wr

    task rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0, d, e);
        chk(nm, d, exp);
    endtask : rd

    task to(input int n);
        while (cyc < n) @(posedge pclk);
    endtask : to

    // monitors: event capture, pass spacing, operand update moment
    always @(posedge pclk) begin
        if (presetn) begin
            cyc <= cyc + 1;
            op_prev <= operand;
            if (event_out.valid === 1'b1) evq.push_back(event_out);
            if (operand !== op_prev) chk("operand moment", pass_start, 1);
            if (pass_start === 1'b1) begin
                if (gap_seen) chk("pass gap", gap, 100);
                gap_seen <= 1'b1;
                gap <= 1;
            end else begin
                gap <= gap + 1;
            end
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        $display("[ERR] watchdog expected end seen hang");
        conclude();
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(`ADDR_CTRL, `CTRL_RST, "ctrl rst");
        rd(`ADDR_DEB, `DEB_RST, "deb rst");
        rd(`ADDR_THR, `THR_RST, "thr rst");
        rd(`ADDR_EV_EN, 0, "ev_en rst");
        rd(`ADDR_MASK, `MASK16_RST, "mask rst");
        rd(`ADDR_STATE, 0, "state rst");
        rd(`ADDR_OPERAND, 0, "operand rst");
        // unmapped write is refused and must not land
        apb(1'b1, 12'h040, 32'hffffffff, d, e);
        chk("unmapped err", e, 1);
        chk("unmapped data", d, 0);
        rd(`ADDR_MASK, `MASK16_RST, "mask kept");
        // group 0 threshold equals the wet level, group 1 above it
        wr(`ADDR_THR, 32'h10104020);
        rd(`ADDR_THR, 32'h10104020, "thr");
        wr(`ADDR_EV_EN, 32'h1);
        wr(`ADDR_MASK, 32'h1);
        // three closed samples, one open sample, then a real closure
        to(4100); closed <= 16'h0003;
        to(4700); closed <= 16'h0000;
        to(4900); closed <= 16'h0013;
        to(5900); rd(`ADDR_STATE, 0, "state early");
        chk("no event yet", evq.size(), 0);
        to(6200); rd(`ADDR_STATE, 32'h3, "state closed");
        rd(`ADDR_OPERAND, 32'h3, "operand reg");
        chk("operand", operand, 16'h0003);
        chk("events", evq.size(), 1);
        ev = evq.pop_front();
        chk("ev chan", ev.chan, 0);
        chk("ev closed", ev.closed, 1);
        t0 = ev.stamp;
        // first sample of the run is at cycle 5001, i.e. 50 us
        chk("ev stamp", t0, 32'd50);
        chk("irq set", irq, 1);
        rd(`ADDR_STATUS, 32'h3, "status");
        wr(`ADDR_STATUS, 32'h1);
        rd(`ADDR_STATUS, 32'h2, "status w1c");
        chk("irq masked", irq, 0);
        wr(`ADDR_MASK, 32'h3);
        rd(`ADDR_MASK, 32'h3, "mask");
        chk("irq unmasked", irq, 1);
        wr(`ADDR_STATUS, 32'h2);
        rd(`ADDR_STATUS, 32'h0, "status clear");
        chk("irq clear", irq, 0);
        // opening 2000 cycles after the reclosure: stamps 20 us apart
        to(6900); closed <= 16'h0010;
        to(7900); rd(`ADDR_STATE, 32'h3, "state hold");
        to(8200); rd(`ADDR_STATE, 0, "state open");
        chk("operand open", operand, 16'h0000);
        chk("events open", evq.size(), 1);
        ev = evq.pop_front();
        chk("ev open", ev.closed, 0);
        chk("stamp span", ev.stamp - t0, 32'd20);
        rd(`ADDR_STATUS, 32'h3, "status again");
        chk("irq again", irq, 1);
        // scan off freezes every run
        wr(`ADDR_CTRL, 32'h0);
        rd(`ADDR_CTRL, 32'h0, "ctrl off");
        to(8500); closed <= 16'h0001;
        to(9800); rd(`ADDR_STATE, 0, "state frozen");
        wr(`ADDR_CTRL, 32'h1);
        to(11200); rd(`ADDR_STATE, 32'h1, "state resumed");
        conclude();
    end
endmodule : tb_top
